// ### ccp_pkg.sv
// Constants, field positions and carrier types for the capture/compare control block.
// Assumes one module clock; register offsets are byte addresses on an AXI4-Lite bus.
package ccp_pkg;

	// ==========================================================
	// Register byte offsets.
	localparam logic [7:0] OFS_STEER = 8'h00;
	localparam logic [7:0] OFS_DT    = 8'h04;
	localparam logic [7:0] OFS_MODE  = 8'h08;
	localparam logic [7:0] OFS_STAT  = 8'h0c;
	localparam logic [7:0] OFS_TRIG  = 8'h10;
	localparam logic [7:0] OFS_RST   = 8'h14;

	// ==========================================================
	// Reset values and writable-bit masks.
	localparam logic [15:0] RST_STEER  = 16'h0100;
	localparam logic [15:0] RST_ZERO   = 16'h0000;
	localparam logic [15:0] MASK_STEER = 16'hbfdf;
	localparam logic [15:0] MASK_DT    = 16'h003f;
	localparam logic [15:0] MASK_MODE  = 16'hf73f;
	localparam logic [15:0] MASK_TRIG  = 16'h00c0;
	localparam logic [15:0] MASK_RST   = 16'h8000;

	// ==========================================================
	// Field positions.
	localparam int B_OE_SYNC = 15;
	localparam int B_STEER   = 8;
	localparam int B_GATE    = 6;
	localparam int B_AUX     = 3;
	localparam int B_SRC     = 0;
	localparam int B_HOLD    = 15;
	localparam int B_OSC     = 12;
	localparam int B_OUTPUT_MODE_SELECT    = 8;
	localparam int B_POL1    = 5;
	localparam int B_POL2    = 4;
	localparam int B_PSS1    = 2;
	localparam int B_PSS2    = 0;
	localparam int B_ARM     = 10;
	localparam int B_TSTAT   = 7;
	localparam int B_TSET    = 6;
	localparam int B_TCLR    = 5;
	localparam int B_SHD     = 4;
	localparam int B_CMP     = 3;
	localparam int B_DIS     = 2;
	localparam int B_OVF     = 1;
	localparam int B_BNE     = 0;
	localparam int B_TRIGGER_MODE_ENABLE  = 7;
	localparam int B_ONE_SHOT_ENABLE = 6;
	localparam int B_RSEN    = 15;

	// ==========================================================
	// Mode codes.
	localparam logic [1:0] GATE_LEVEL = 2'b00;
	localparam logic [1:0] GATE_RISE  = 2'b01;
	localparam logic [1:0] GATE_FALL  = 2'b10;
	localparam logic [1:0] AUX_OFF    = 2'b00;
	localparam logic [1:0] AUX_ROLL   = 2'b01;
	localparam logic [1:0] AUX_MODE   = 2'b10;
	localparam logic [1:0] AUX_EVT    = 2'b11;
	localparam logic [2:0] OUTPUT_MODE_SELECT_SINGLE = 3'b000;
	localparam logic [2:0] OUTPUT_MODE_SELECT_PUSH   = 3'b001;
	localparam logic [2:0] OUTPUT_MODE_SELECT_HALF   = 3'b010;
	localparam logic [2:0] OUTPUT_MODE_SELECT_REV    = 3'b100;
	localparam logic [2:0] OUTPUT_MODE_SELECT_FWD    = 3'b101;
	localparam logic [2:0] OUTPUT_MODE_SELECT_SCAN   = 3'b110;
	localparam logic [2:0] SCAN_LAST   = 3'h5;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// ==========================================================
	// Carrier types.
	typedef struct packed {
		logic       shutdown_in;
		logic       gate_src;
		logic [1:0] logic_cell;
		logic [2:0] comparator;
		logic       capture_input_pin;
	} ccp_src_s;

	typedef struct packed {
		logic tb_rollover;
		logic hw_trigger;
		logic pwm_raw;
		logic mode_signal;
		logic timer_mode;
		logic single_edge_cmp;
		logic cap_fifo_overflow;
		logic cap_buf_not_empty;
	} ccp_evt_s;

	typedef struct packed {
		logic [5:0] level;
		logic [5:0] oe;
	} ccp_pins_s;

endpackage

// ### ccp_sync2.sv
// Two-flop synchroniser for a vector of unrelated asynchronous levels.
// Assumes each bit is a slow level; no bus coherency is kept across bits.
`timescale 1ns/10ps
module ccp_sync2 #(
	parameter int W = 8
) (
	// Clock and reset.
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Levels.
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q   <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end

endmodule

// ### ccp_ctrl.sv
// Capture/compare output steering, gating, trigger and status control with an AXI4-Lite slave.
// Assumes a time base, compare and capture datapath outside supplying events on the same clock.
//
// What this block does
// (R1) Sync bit defers steering enables to rollover.
// (R2) Steering enable gives module the pin.
// (R3) Gating mode 00 follows source level.
// (R4) Modes 01/10: rise clears, fall sets disable.
// (R5) Aux output select picks event source.
// (R6) Capture source select chooses pin/comparator/cell.
// (R7) Dead time blanks complementary outputs N periods.
// (R8) Dead time, mode, group two: first instance.
// (R9) Hold outputs off until triggered.
// (R10) One-shot lasts count plus one periods.
// (R11) Output mode field selects pin pattern.
// (R12) Group polarity bits invert outputs.
// (R13) Shutdown state drives active, inactive, tristate.
// (R14) Gate arm write arms one-shot gating.
// (R15) Trigger status shows triggered running timer.
// (R16) Trigger set request triggers timer.
// (R17) Trigger clear request cancels trigger.
// (R18) Shutdown flag set during shutdown.
// (R19) Compare flag sticky until cleared.
// (R20) Disable flag blocks capture events.
// (R21) Overflow flag sticky until cleared.
// (R22) Buffer-not-empty follows buffer level.
// (R23) Trigger mode enable gates triggered operation.
// (R24) One-shot enable makes trigger one-shot.
// (R25) Restart enable auto-clears shutdown flag.
// (R26) Software clears flags by writing zero.
//
// Added by the designer: the AXI4-Lite slave port and the address map.
`timescale 1ns/10ps
module ccp_ctrl
	import ccp_pkg::*;
#(
	parameter bit FIRST_INSTANCE = 1'b1
) (
	// Clock and reset.
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// AXI4-Lite write channels.
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Asynchronous pins and internal events.
	input  wire ccp_src_s    src,
	input  wire ccp_evt_s    evt,
	// Pin and event outputs.
	output ccp_pins_s        pins,
	output logic             cap_event,
	output logic             aux_out,
	output logic             trigger_status,
	output logic             tb_run
);

	// ==========================================================
	// Helpers.
	function automatic logic ofs_hit(input logic [7:0] a);
		ofs_hit = (a == OFS_STEER) || (a == OFS_DT) || (a == OFS_MODE) ||
			(a == OFS_STAT) || (a == OFS_TRIG) || (a == OFS_RST);
	endfunction

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] dat,
		input logic [15:0] lanes, input logic [15:0] mask);
		merge = ((old & ~lanes) | (dat & lanes)) & mask;
	endfunction

	// ==========================================================
	// State.
	logic [15:0] steer_q;
	logic [15:0] dt_q;
	logic [15:0] mode_q;
	logic [15:0] trig_q;
	logic [15:0] rst_q;
	logic        aw_q;
	logic        w_q;
	logic [7:0]  awaddr_q;
	logic [15:0] wdata_q;
	logic [15:0] lanes_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [1:0]  rresp_q;
	logic [31:0] rdata_q;
	logic [5:0]  steer_act_q;
	logic        armed_q;
	logic        cap_dis_q;
	logic        gate_prev_q;
	logic        sel_prev_q;
	logic        triggered_q;
	logic [2:0]  os_cnt_q;
	logic        shd_q;
	logic        cmp_q;
	logic        ovf_q;
	logic        pwm_prev_q;
	logic [5:0]  dt_cnt_q;
	logic        pp_q;
	logic [2:0]  scan_q;
	logic        cap_event_q;
	logic        aux_q;
	ccp_pins_s   pins_q;
	ccp_src_s    sync;

	// ==========================================================
	// Pin inputs pass two flops.
	ccp_sync2 #(.W($bits(ccp_src_s))) u_sync (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.async_in (src),
		.sync_out (sync)
	);

	// ==========================================================
	// Bus handshakes and decoded write strobes.
	logic        commit;
	logic        wr_steer, wr_dt, wr_mode, wr_stat, wr_trig, wr_rst;
	logic [15:0] wr1;
	logic [15:0] wr0;

	assign s_axi_awready = !aw_q && !bvalid_q;
	assign s_axi_wready  = !w_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;
	assign commit   = aw_q && w_q;
	assign wr_steer = commit && (awaddr_q == OFS_STEER);
	assign wr_dt    = commit && (awaddr_q == OFS_DT) && FIRST_INSTANCE; // R8
	assign wr_mode  = commit && (awaddr_q == OFS_MODE);
	assign wr_stat  = commit && (awaddr_q == OFS_STAT);
	assign wr_trig  = commit && (awaddr_q == OFS_TRIG);
	assign wr_rst   = commit && (awaddr_q == OFS_RST);
	assign wr1 = {16{wr_stat}} & wdata_q & lanes_q;
	assign wr0 = {16{wr_stat}} & ~wdata_q & lanes_q;

	// Write address and data are caught in either order; the response follows both.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_q     <= 1'b0;
			w_q      <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q  <= 16'h0000;
			lanes_q  <= 16'h0000;
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_q     <= 1'b1;
				awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_q     <= 1'b1;
				wdata_q <= s_axi_wdata[15:0];
				lanes_q <= {{8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
			end
			if (commit)
			begin
				aw_q     <= 1'b0;
				w_q      <= 1'b0;
				bvalid_q <= 1'b1;
				bresp_q  <= ofs_hit(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bvalid_q && s_axi_bready)
				bvalid_q <= 1'b0;
		end
	end

	// Read data is sampled on the same edge that takes the address.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= ofs_hit({s_axi_araddr[7:2], 2'b00}) ? RESP_OKAY : RESP_SLVERR;
			rdata_q  <= 32'h0000_0000;
			if ({s_axi_araddr[7:2], 2'b00} == OFS_STEER)
				rdata_q[15:0] <= steer_q;
			else if ({s_axi_araddr[7:2], 2'b00} == OFS_DT)
				rdata_q[15:0] <= dt_q;
			else if ({s_axi_araddr[7:2], 2'b00} == OFS_MODE)
				rdata_q[15:0] <= mode_q;
			else if ({s_axi_araddr[7:2], 2'b00} == OFS_STAT)
				rdata_q[15:0] <= {8'h00, triggered_q, 2'b00, shd_q, cmp_q, cap_dis_q, ovf_q,
					evt.cap_buf_not_empty}; // R14 R15 R16 R17 R22
			else if ({s_axi_araddr[7:2], 2'b00} == OFS_TRIG)
				rdata_q[15:0] <= trig_q;
			else if ({s_axi_araddr[7:2], 2'b00} == OFS_RST)
				rdata_q[15:0] <= rst_q;
		end
		else if (rvalid_q && s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ==========================================================
	// Control registers; later-instance fields stay zero.
	logic [15:0] mode_mask;
	assign mode_mask = FIRST_INSTANCE ? MASK_MODE : (MASK_MODE & 16'hf02c); // R8

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			steer_q <= RST_STEER;
			dt_q    <= RST_ZERO;
			mode_q  <= RST_ZERO;
			trig_q  <= RST_ZERO;
			rst_q   <= RST_ZERO;
		end
		else
		begin
			if (wr_steer)
				steer_q <= merge(steer_q, wdata_q, lanes_q, MASK_STEER);
			if (wr_dt)
				dt_q <= merge(dt_q, wdata_q, lanes_q, MASK_DT);
			if (wr_mode)
				mode_q <= merge(mode_q, wdata_q, lanes_q, mode_mask);
			if (wr_trig)
				trig_q <= merge(trig_q, wdata_q, lanes_q, MASK_TRIG);
			if (wr_rst)
				rst_q <= merge(rst_q, wdata_q, lanes_q, MASK_RST);
		end
	end

	// Steering enables update at once or on the next rollover.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			steer_act_q <= RST_STEER[13:8];
		else if (!steer_q[B_OE_SYNC] || evt.tb_rollover) // R1
			steer_act_q <= steer_q[B_STEER +: 6];
	end

	// ==========================================================
	// Capture gating and capture events.
	logic [1:0] gate_mode;
	logic       gate_rise;
	logic       gate_fall;
	logic [2:0] src_sel;
	logic       cap_src;

	assign gate_mode = steer_q[B_GATE +: 2];
	assign gate_rise = sync.gate_src && !gate_prev_q;
	assign gate_fall = !sync.gate_src && gate_prev_q;
	assign src_sel   = steer_q[B_SRC +: 3];

	// Source select; reserved codes give no source.
	always_comb
	begin
		case (src_sel) // R6
			3'b000:  cap_src = sync.capture_input_pin;
			3'b001:  cap_src = sync.comparator[0];
			3'b010:  cap_src = sync.comparator[1];
			3'b011:  cap_src = sync.comparator[2];
			3'b100:  cap_src = sync.logic_cell[0];
			3'b101:  cap_src = sync.logic_cell[1];
			default: cap_src = 1'b0;
		endcase
	end

	// Arm, disable flag and event edge; a hardware set beats a software clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			armed_q     <= 1'b0;
			cap_dis_q   <= 1'b0;
			gate_prev_q <= 1'b0;
			sel_prev_q  <= 1'b0;
			cap_event_q <= 1'b0;
		end
		else
		begin
			gate_prev_q <= sync.gate_src;
			sel_prev_q  <= cap_src;
			cap_event_q <= cap_src && !sel_prev_q && !cap_dis_q; // R20
			if (wr0[B_DIS])
				cap_dis_q <= 1'b0; // R26
			if (wr1[B_ARM] && (gate_mode == GATE_RISE || gate_mode == GATE_FALL))
				armed_q <= 1'b1; // R14
			if (gate_mode == GATE_LEVEL)
				cap_dis_q <= !sync.gate_src; // R3
			else if (armed_q && gate_mode == GATE_RISE && gate_rise)
			begin
				cap_dis_q <= 1'b0; // R4
				armed_q   <= 1'b0;
			end
			else if (armed_q && gate_mode == GATE_FALL && gate_fall)
			begin
				cap_dis_q <= 1'b1; // R4
				armed_q   <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Trigger and one-shot length.
	logic trig_en;
	logic trig_set;
	assign trig_en  = trig_q[B_TRIGGER_MODE_ENABLE];
	assign trig_set = trig_en && (wr1[B_TSET] || evt.hw_trigger); // R16 R23

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			triggered_q <= 1'b0;
			os_cnt_q    <= 3'h0;
		end
		else if (!trig_en)
			triggered_q <= 1'b0; // R23
		else if (trig_set)
		begin
			triggered_q <= 1'b1; // R16
			os_cnt_q    <= 3'h0;
		end
		else if (wr1[B_TCLR])
			triggered_q <= 1'b0; // R17
		else if (triggered_q && trig_q[B_ONE_SHOT_ENABLE] && evt.tb_rollover) // R24
		begin
			if (os_cnt_q == mode_q[B_OSC +: 3])
				triggered_q <= 1'b0; // R10
			else
				os_cnt_q <= os_cnt_q + 3'h1;
		end
	end

	assign trigger_status = triggered_q; // R15
	assign tb_run = !trig_en || triggered_q;

	// ==========================================================
	// Sticky status flags; set beats clear.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			shd_q <= 1'b0;
			cmp_q <= 1'b0;
			ovf_q <= 1'b0;
		end
		else
		begin
			if (wr0[B_SHD] || (rst_q[B_RSEN] && evt.tb_rollover && !sync.shutdown_in)) // R25 R26
				shd_q <= 1'b0;
			if (sync.shutdown_in)
				shd_q <= 1'b1; // R18
			if (wr0[B_CMP])
				cmp_q <= 1'b0;
			if (evt.single_edge_cmp)
				cmp_q <= 1'b1; // R19
			if (wr0[B_OVF])
				ovf_q <= 1'b0;
			if (evt.cap_fifo_overflow)
				ovf_q <= 1'b1; // R21
		end
	end

	// ==========================================================
	// Output patterns: dead time, push-pull phase and scan position.
	logic       dt_busy;
	logic [2:0] output_mode_select;
	logic [5:0] act;
	logic [5:0] pol;
	logic       hold;

	assign dt_busy = (dt_cnt_q != 6'h00) || ((evt.pwm_raw != pwm_prev_q) && (dt_q[5:0] != 6'h00));
	assign output_mode_select    = mode_q[B_OUTPUT_MODE_SELECT +: 3];
	assign pol     = {3{mode_q[B_POL2], mode_q[B_POL1]}}; // R12
	assign hold    = mode_q[B_HOLD] && trig_en && !triggered_q; // R9

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pwm_prev_q <= 1'b0;
			dt_cnt_q   <= 6'h00;
			pp_q       <= 1'b0;
			scan_q     <= 3'h0;
		end
		else
		begin
			pwm_prev_q <= evt.pwm_raw;
			if (evt.pwm_raw != pwm_prev_q && dt_q[5:0] != 6'h00)
				dt_cnt_q <= dt_q[5:0] - 6'h01; // R7
			else if (dt_cnt_q != 6'h00)
				dt_cnt_q <= dt_cnt_q - 6'h01;
			if (evt.tb_rollover)
			begin
				pp_q   <= !pp_q;
				scan_q <= (scan_q == SCAN_LAST) ? 3'h0 : scan_q + 3'h1;
			end
		end
	end

	// Logical (active-high) pin pattern per output mode.
	always_comb
	begin
		act = 6'h00;
		case (output_mode_select) // R11
			OUTPUT_MODE_SELECT_SINGLE: act = {6{evt.pwm_raw}};
			OUTPUT_MODE_SELECT_PUSH:   act = {4'h0, evt.pwm_raw && !pp_q, evt.pwm_raw && pp_q};
			OUTPUT_MODE_SELECT_HALF:   act = {4'h0, !evt.pwm_raw && !dt_busy, evt.pwm_raw && !dt_busy}; // R7
			OUTPUT_MODE_SELECT_REV:    act = {3'h0, evt.pwm_raw, 1'b1, 1'b0};
			OUTPUT_MODE_SELECT_FWD:    act = {2'h0, evt.pwm_raw, 2'h0, 1'b1};
			OUTPUT_MODE_SELECT_SCAN:   act = (6'h01 << scan_q) & {6{evt.pwm_raw}};
			default:     act = 6'h00;
		endcase
	end

	// Pin drive with polarity, shutdown state, hold and steering.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			pins_q <= '0;
		else
		begin
			for (int i = 0; i < 6; i++)
			begin
				logic [1:0] pss;
				pss = (i % 2 == 0) ? mode_q[B_PSS1 +: 2] : mode_q[B_PSS2 +: 2];
				pins_q.level[i] <= act[i] ^ pol[i]; // R12
				pins_q.oe[i]    <= steer_act_q[i] && !hold; // R2 R9
				if (shd_q)
				begin
					pins_q.level[i] <= pss[0] ^ pol[i]; // R13
					if (!pss[1])
						pins_q.oe[i] <= 1'b0; // R13
				end
			end
		end
	end

	assign pins      = pins_q;
	assign cap_event = cap_event_q;

	// ==========================================================
	// Auxiliary output event.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			aux_q <= 1'b0;
		else
		begin
			case (steer_q[B_AUX +: 2]) // R5
				AUX_ROLL: aux_q <= evt.tb_rollover;
				AUX_MODE: aux_q <= evt.mode_signal;
				AUX_EVT:  aux_q <= !evt.timer_mode && (cap_event_q || evt.single_edge_cmp);
				default:  aux_q <= 1'b0;
			endcase
		end
	end

	assign aux_out = aux_q;

endmodule

// ### ccp_ctrl_sva.sv
// Concurrent checks on the bus and pin ports of the capture/compare control block.
// Assumes it is bound into ccp_ctrl; one clock, synchronous active-low reset.
`timescale 1ns/10ps
module ccp_ctrl_sva
	import ccp_pkg::*;
(
	// Clock and reset.
	input wire logic        aclk,
	input wire logic        aresetn,
	// Bus handshakes.
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Pins and status.
	input wire ccp_pins_s   pins,
	input wire logic        cap_event,
	input wire logic        trigger_status,
	input wire logic        tb_run
);
	// ==========================================================
	// Helper logic.
	logic [7:0] rd_addr_q;

	// Remembers the offset of the read being answered.
	always_ff @(posedge aclk)
	begin
		if (s_axi_arvalid && s_axi_arready)
		begin
			rd_addr_q <= {s_axi_araddr[7:2], 2'b00};
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// Assertions.
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	busy_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	unmapped_rd_a: assert property (s_axi_rvalid && rd_addr_q > OFS_RST |-> s_axi_rresp == RESP_SLVERR)
		else $error("unmapped read not refused");
	stat_wonly_a: assert property (s_axi_rvalid && rd_addr_q == OFS_STAT |-> s_axi_rdata[10] == 1'b0
		&& s_axi_rdata[6:5] == 2'b00) else $error("request bits read back nonzero");
	reset_pins_a: assert property (disable iff (1'b0) !aresetn |=> pins.oe == 6'h00 && !cap_event)
		else $error("pins driven after reset");
	cap_pulse_a: assert property (cap_event |=> !cap_event)
		else $error("capture event longer than one cycle");
	trig_run_a: assert property ($rose(trigger_status) |-> tb_run && !$past(tb_run))
		else $error("trigger status rose without a running timer");

	// Main scenarios reached.
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (cap_event);
	cover property ($rose(trigger_status));
endmodule

bind ccp_ctrl ccp_ctrl_sva ccp_ctrl_sva_inst (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pins(pins), .cap_event(cap_event), .trigger_status(trigger_status),
	.tb_run(tb_run)
);

// ### ccp_far_model.sv
// Far-side model: time base rollover, internal events and capture-side pin levels.
// Assumes the bench commands levels and pulses; the model lands them after a clock edge.
`timescale 1ns/10ps
module ccp_far_model
	import ccp_pkg::*;
#(
	parameter int ROLL_PERIOD = 40
) (
	// Clock and reset.
	input  wire logic     aclk,
	input  wire logic     aresetn,
	// Bench commands.
	input  wire ccp_src_s src_cmd,
	input  wire ccp_evt_s evt_cmd,
	// Drive into the block.
	output ccp_src_s      src,
	output ccp_evt_s      evt
);
	logic [7:0] roll_cnt_q;

	// Free-running time base that wraps once a period.
	always_ff @(posedge aclk)
	begin
		if (!aresetn || roll_cnt_q == 8'(ROLL_PERIOD - 1))
		begin
			roll_cnt_q <= 8'h00;
		end
		else
		begin
			roll_cnt_q <= roll_cnt_q + 8'h01;
		end
	end

	// Pins and events change just after an edge; rollover pulses at the wrap.
	always_ff @(posedge aclk)
	begin
		src <= src_cmd;
		evt <= evt_cmd;
		evt.tb_rollover <= aresetn && roll_cnt_q == 8'(ROLL_PERIOD - 1);
	end
endmodule

// ### tb_capture_compare_output_and_status.sv
// Self-checking bench for the capture/compare control block.
// Assumes ccp_ctrl, its far-side model and the bound checker; 10 MHz clock.
`timescale 1ns/10ps
`define CHK(got, exp) \
	begin \
		comparisons++; \
		if ((got) !== (exp)) \
		begin \
			error_cnt++; \
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
		end \
	end
module tb_capture_compare_output_and_status
	import ccp_pkg::*;
();
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, cap_event, aux_out, trigger_status, tb_run;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	logic [15:0] v;
	logic [5:0]  oe_a, oe_b;
	logic [7:0]  ofs [3] = '{OFS_STEER, OFS_DT, OFS_MODE};
	ccp_src_s    src_cmd, src;
	ccp_evt_s    evt_cmd, evt;
	ccp_pins_s   pins;
	int          error_cnt, comparisons, cap_cnt, n0;

	ccp_ctrl ccp_ctrl_inst (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .src(src), .evt(evt), .pins(pins), .cap_event(cap_event), .aux_out(aux_out),
		.trigger_status(trigger_status), .tb_run(tb_run)
	);
	ccp_far_model ccp_far_model_inst (.aclk(aclk), .aresetn(aresetn), .src_cmd(src_cmd), .evt_cmd(evt_cmd),
		.src(src), .evt(evt));

	// Clock at a 100 ns period.
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Capture pulses seen at the block's output.
	always @(posedge aclk)
	begin
		if (cap_event === 1'b1)
			cap_cnt++;
	end

	// Value a control register reads back after a write.
	function automatic logic [15:0] masked(input logic [7:0] a, input logic [15:0] x);
		return x & (a == OFS_STEER ? MASK_STEER : a == OFS_DT ? MASK_DT : MASK_MODE);
	endfunction

	// One bus transfer; each channel is held until taken, then the answer is kept.
	task automatic xfer(input bit w, input logic [7:0] a, input logic [15:0] x);
		@(posedge aclk);
		{awaddr, araddr, wdata} <= {a, a, 16'h0000, x};
		{awvalid, wvalid, bready, arvalid, rready} <= {w, w, w, !w, !w};
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (arready)
				arvalid <= 1'b0;
		end
		while (!(bvalid && bready || rvalid && rready));
		d = rdata;
		r = w ? bresp : rresp;
		{bready, rready} <= 2'b00;
	endtask

	// Prints the counts and the verdict, then stops.
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Cuts a hang short.
	initial
	begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		end_of_test;
	end

	// Reset, then the scenarios in turn.
	initial
	begin
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready, src_cmd, evt_cmd} = '0;
		{error_cnt, comparisons, cap_cnt, aresetn} = '0;
		void'($urandom(1));
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		xfer(0, OFS_STEER, 0);
		`CHK(d, {16'h0000, RST_STEER})
		xfer(0, 8'h18, 0);
		`CHK({r, d}, {RESP_SLVERR, 32'h0})
		// Every output mode code, random other bits, full dead time once.
		for (int i = 0; i < 24; i++)
		begin
			v = 16'($urandom);
			v[10:8] = 3'(i / 3);
			if (i == 22)
				v[5:0] = 6'h3f;
			xfer(1, ofs[i % 3], v);
			xfer(0, ofs[i % 3], 0);
			`CHK(d[15:0], masked(ofs[i % 3], v))
		end
		// Steering at once with the sync bit clear, at rollover with it set.
		xfer(1, OFS_MODE, 16'h0000);
		oe_a = 6'($urandom);
		oe_b = ~oe_a;
		xfer(1, OFS_STEER, {2'b00, oe_a, 8'h00});
		repeat (2) @(posedge aclk);
		`CHK(pins.oe, oe_a)
		@(posedge aclk iff evt.tb_rollover);
		xfer(1, OFS_STEER, {2'b10, oe_b, 8'h00});
		repeat (2) @(posedge aclk);
		`CHK(pins.oe, oe_a)
		@(posedge aclk iff evt.tb_rollover);
		repeat (2) @(posedge aclk);
		`CHK(pins.oe, oe_b)
		// Flags set by events; one-writes leave them, zero-writes clear the compare and overflow flags.
		evt_cmd.single_edge_cmp <= 1'b1;
		evt_cmd.cap_fifo_overflow <= 1'b1;
		evt_cmd.cap_buf_not_empty <= 1'b1;
		@(posedge aclk);
		{evt_cmd.single_edge_cmp, evt_cmd.cap_fifo_overflow} <= 2'b00;
		xfer(1, OFS_STAT, 16'h001f);
		xfer(0, OFS_STAT, 0);
		`CHK(d[15:0], 16'h000f)
		xfer(1, OFS_STAT, 16'h0000);
		xfer(0, OFS_STAT, 0);
		`CHK(d[15:0], 16'h0005)
		// Capture edges pass only while the gate level is high.
		for (int g = 1; g >= 0; g--)
		begin
			src_cmd.gate_src <= g[0];
			repeat (6) @(posedge aclk);
			n0 = cap_cnt;
			src_cmd.capture_input_pin <= 1'b1;
			repeat (6) @(posedge aclk);
			src_cmd.capture_input_pin <= 1'b0;
			repeat (2) @(posedge aclk);
			`CHK(cap_cnt - n0, g)
		end
		// Armed rising-edge gating clears the disable flag; aux output shows rollover.
		xfer(1, OFS_STEER, {2'b10, oe_b, 8'h48});
		xfer(1, OFS_STAT, 16'h0404);
		src_cmd.gate_src <= 1'b1;
		@(posedge aclk iff evt.tb_rollover);
		@(posedge aclk);
		`CHK(aux_out, 1'b1)
		repeat (4) @(posedge aclk);
		xfer(0, OFS_STAT, 0);
		`CHK(d[2], 1'b0)
		// Triggered operation: held, set, cleared, outputs held until triggered.
		xfer(1, OFS_TRIG, 16'h0080);
		repeat (2) @(posedge aclk);
		`CHK(tb_run, 1'b0)
		xfer(1, OFS_MODE, 16'h8030);
		repeat (2) @(posedge aclk);
		`CHK(pins, {6'h3f, 6'h00})
		xfer(1, OFS_STAT, 16'h0040);
		repeat (2) @(posedge aclk);
		`CHK({trigger_status, tb_run, pins.oe}, {2'b11, oe_b})
		// Shutdown with state code 00 releases every pin and sets the flag.
		src_cmd.shutdown_in <= 1'b1;
		repeat (6) @(posedge aclk);
		`CHK(pins.oe, 6'h00)
		xfer(0, OFS_STAT, 0);
		`CHK(d[4], 1'b1)
		xfer(1, OFS_STAT, 16'h0020);
		repeat (2) @(posedge aclk);
		`CHK({trigger_status, tb_run}, 2'b00)
		end_of_test;
	end
endmodule
